// ---- rtl/canopen_nmt_sdo_slave.v ----
// CANopen slave: NMT, SYNC window, EMCY and expedited SDO handling
// Function
// - Node identifier lies in 1..127; zero or out-of-range ID is ignored.
// - Initialization only after reset or reset commands, then pre-operational.
// - PDO only operational; SDO/SYNC/EMCY pre-op and op; stopped takes NMT.
// - NMT frames use CAN ID 0 with two bytes: command, node.
// - Commands 01 oper, 02 stop, 80 pre-op, 81 reset node, 82 reset comm.
// - Node byte zero is broadcast; nonzero matches own node only.
// - Reset node restarts all; reset comm resets communication settings only.
// - On SYNC commit RX process data and sample TX process data.
// - PDOs only inside the sync window set in milliseconds by 1007.
// - RX PDO type 0 acts at next sync; TX type 1..240.
// - Emergency sent on 80h plus node for non-SDO internal errors.
// - Emergency carries error code, error register and manufacturer code.
// - Error sets bit in 1001, history stored in 1003 subindex 1.
// - With no errors pending, an all-zero emergency frame is sent.
// - SDO requests on 600h plus node, replies on 580h plus node.
// - Index in bytes 1-2 LSB first, subindex byte 3, echoed in reply.
// - Expedited transfer serves objects of at most four bytes.
// - Write command encodes length: 2F, 2B, 27, 23.
// - Data is little endian, LSB in data byte 4.
// - Write OK answers 60 plus echo; failure 80 plus 32-bit code.
// - Read reply encodes length: 4F, 4B, 47, 43.
// - Every expedited request receives exactly one answer; code drops one arriving while a reply is built or pending.
// - Every SDO frame has eight data bytes, unused bytes zero.
// - Unknown command byte rejected with code 05040001.
`timescale 1ns/100ps
`default_nettype none
`include "canopen_nmt_sdo_slave_defines.vh"
module canopen_nmt_sdo_slave #(
   parameter MS_CYC = `MS_CYCLES,
   parameter OD_AW = 4
) (
   // Clock and reset
   input wire clk,
   input wire nrst,
   // Configuration
   input wire [6:0] node_id,
   input wire [7:0] tx_trans_type,
   // Received frame, same clock domain
   input wire rx_valid,
   input wire [10:0] rx_id,
   input wire [3:0] rx_dlc,
   input wire [63:0] rx_data,
   // Transmit frame
   output reg tx_valid,
   output reg [10:0] tx_id,
   output reg [3:0] tx_dlc,
   output reg [63:0] tx_data,
   input wire tx_ready,
   // Internal error reporting
   input wire err_event,
   input wire [15:0] emergency_error_code,
   input wire [2:0] err_bit,
   input wire [39:0] err_mfr_code,
   input wire err_clear,
   // Process data
   input wire [31:0] rpdo_data,
   input wire rpdo_valid,
   input wire [31:0] app_data,
   output reg [31:0] rpdo_committed,
   output reg [31:0] tpdo_data,
   output reg tpdo_start,
   output reg pdo_window,
   // Status
   output reg [1:0] nmt_state,
   output reg node_reset,
   output reg comm_reset,
   output reg [7:0] error_register
);
   // ----------------------------------------------------------------
   // Frame classification
   // ----------------------------------------------------------------
   localparam S_IDLE = 2'h0;
   localparam S_READ = 2'h1;
   localparam S_SEND = 2'h2;

   wire node_ok = (node_id != 7'h00);
   wire [10:0] own_sdo_rx = `ID_SDO_RX_BASE + {4'h0, node_id};
   wire is_nmt = rx_valid && rx_id == `ID_NMT && rx_dlc == 4'h2;
   wire nmt_hit = is_nmt && node_ok && (rx_data[15:8] == 8'h00 ||
      rx_data[15:8] == {1'b0, node_id});
   wire is_sync = rx_valid && rx_id == `ID_SYNC;
   wire is_sdo = rx_valid && node_ok && rx_id == own_sdo_rx &&
      rx_dlc == 4'h8;
   wire svc_on = nmt_state == `ST_PREOP || nmt_state == `ST_OPER;

   // Byte count of an expedited write command, zero if not one
   function [2:0] dl_len;
      input [7:0] c;
      begin
         case (c)
            `SDO_DL_1: dl_len = 3'd1;
            `SDO_DL_2: dl_len = 3'd2;
            `SDO_DL_3: dl_len = 3'd3;
            `SDO_DL_4: dl_len = 3'd4;
            default: dl_len = 3'd0;
         endcase
      end
   endfunction

   // Byte mask for a length
   function [31:0] len_mask;
      input [2:0] n;
      begin
         case (n)
            3'd1: len_mask = 32'h000000FF;
            3'd2: len_mask = 32'h0000FFFF;
            3'd3: len_mask = 32'h00FFFFFF;
            default: len_mask = 32'hFFFFFFFF;
         endcase
      end
   endfunction

   // ----------------------------------------------------------------
   // Object dictionary store
   // ----------------------------------------------------------------
   reg [7:0] sdo_cmd_r;
   reg [15:0] sdo_idx_r;
   reg [7:0] sdo_sub_r;
   reg [1:0] sdo_st_r;
   reg od_we;
   // Write data latched: the bus moves on once the frame has passed
   reg [31:0] sdo_wdat_r;
   wire [31:0] od_rd;
   wire [OD_AW-1:0] od_addr = sdo_idx_r[OD_AW-1:0] ^ sdo_sub_r[OD_AW-1:0];

   od_ram #(.AW(OD_AW), .DW(32)) u_od (
      .clk(clk),
      .wr_en(od_we),
      .wr_addr(od_addr),
      .wr_data(sdo_wdat_r),
      .rd_addr(od_addr),
      .rd_data(od_rd)
   );

   // ----------------------------------------------------------------
   // NMT state machine
   // ----------------------------------------------------------------
   reg [15:0] sync_win_ms_r;
   reg [15:0] win_ms_cnt_r;
   reg [31:0] ms_cnt_r;
   reg emcy_pend_r;
   reg emcy_zero_r;
   reg boot_pend_r;
   reg [15:0] emcy_code_r;
   reg [39:0] emcy_mfr_r;
   reg [63:0] err_hist_r;
   reg [31:0] rx_hold_r;
   reg sdo_pend_r;
   reg [63:0] sdo_reply_r;

   always @(posedge clk) begin
      if (!nrst) begin
         nmt_state <= `ST_INIT;
         node_reset <= 1'b0;
         comm_reset <= 1'b0;
         boot_pend_r <= 1'b1;
      end else begin
         node_reset <= 1'b0;
         comm_reset <= 1'b0;
         if (nmt_state == `ST_INIT) begin
            nmt_state <= `ST_PREOP;
         end else if (nmt_hit) begin
            case (rx_data[7:0])
               `NMT_START: nmt_state <= `ST_OPER;
               `NMT_STOP: nmt_state <= `ST_STOP;
               `NMT_PREOP: nmt_state <= `ST_PREOP;
               `NMT_RST_NODE: begin
                  nmt_state <= `ST_INIT;
                  node_reset <= 1'b1;
               end
               `NMT_RST_COMM: begin
                  nmt_state <= `ST_INIT;
                  comm_reset <= 1'b1;
               end
               default: nmt_state <= nmt_state;
            endcase
         end
         if (nmt_state == `ST_INIT) begin
            boot_pend_r <= 1'b1;
         end else if (boot_pend_r && tx_ready && !tx_valid) begin
            boot_pend_r <= 1'b0;
         end
      end
   end

   // ----------------------------------------------------------------
   // SYNC, process data and window timing
   // ----------------------------------------------------------------
   wire comm_rst_now = !nrst || node_reset || comm_reset;
   wire tx_sync_type = tx_trans_type >= 8'd1 && tx_trans_type <= 8'd240;

   always @(posedge clk) begin
      if (comm_rst_now) begin
         pdo_window <= 1'b0;
         tpdo_start <= 1'b0;
         win_ms_cnt_r <= 16'h0000;
         ms_cnt_r <= 32'h00000000;
         rx_hold_r <= 32'h00000000;
         rpdo_committed <= 32'h00000000;
         tpdo_data <= 32'h00000000;
      end else begin
         tpdo_start <= 1'b0;
         if (rpdo_valid && pdo_window && nmt_state == `ST_OPER) begin
            rx_hold_r <= rpdo_data;
         end
         if (is_sync && svc_on) begin
            if (nmt_state == `ST_OPER) begin
               rpdo_committed <= rx_hold_r;
               tpdo_data <= app_data;
               tpdo_start <= tx_sync_type;
               pdo_window <= (sync_win_ms_r != 16'h0000);
            end
            win_ms_cnt_r <= sync_win_ms_r;
            ms_cnt_r <= 32'h00000000;
         end else if (pdo_window) begin
            if (nmt_state != `ST_OPER) begin
               pdo_window <= 1'b0;
            end else if (ms_cnt_r == MS_CYC - 1) begin
               ms_cnt_r <= 32'h00000000;
               if (win_ms_cnt_r <= 16'h0001) begin
                  pdo_window <= 1'b0;
               end
               win_ms_cnt_r <= win_ms_cnt_r - 16'h0001;
            end else begin
               ms_cnt_r <= ms_cnt_r + 32'h00000001;
            end
         end
      end
   end

   // ----------------------------------------------------------------
   // Error handling and emergency
   // ----------------------------------------------------------------
   wire emcy_take = tx_ready && !tx_valid && !boot_pend_r &&
      emcy_pend_r && svc_on;

   always @(posedge clk) begin
      if (!nrst || node_reset) begin
         error_register <= 8'h00;
         emcy_pend_r <= 1'b0;
         emcy_zero_r <= 1'b0;
         emcy_code_r <= 16'h0000;
         emcy_mfr_r <= 40'h0000000000;
         err_hist_r <= 64'h0;
      end else if (err_event) begin
         error_register <= error_register | (8'h01 << err_bit);
         err_hist_r <= {err_mfr_code,
            error_register | (8'h01 << err_bit),
            emergency_error_code};
         emcy_code_r <= emergency_error_code;
         emcy_mfr_r <= err_mfr_code;
         emcy_zero_r <= 1'b0;
         emcy_pend_r <= 1'b1;
      end else if (err_clear && error_register != 8'h00) begin
         error_register <= 8'h00;
         emcy_zero_r <= 1'b1;
         emcy_pend_r <= 1'b1;
      end else if (emcy_take) begin
         emcy_pend_r <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // Expedited SDO server
   // ----------------------------------------------------------------
   wire sdo_take = tx_ready && !tx_valid && !boot_pend_r && !emcy_take &&
      sdo_pend_r;
   reg [63:0] reply_nxt;
   reg [2:0] rd_len;

   always @* begin
      rd_len = 3'd4;
      if (sdo_idx_r == `OBJ_ERR_REG) begin
         rd_len = 3'd1;
      end else if (sdo_idx_r == `OBJ_SYNC_WIN) begin
         rd_len = 3'd2;
      end
      reply_nxt = {32'h00000000, sdo_sub_r, sdo_idx_r, 8'h00};
      case (sdo_cmd_r)
         `SDO_UL_REQ: begin
            case (rd_len)
               3'd1: reply_nxt[7:0] = `SDO_UL_1;
               3'd2: reply_nxt[7:0] = `SDO_UL_2;
               default: reply_nxt[7:0] = `SDO_UL_4;
            endcase
            if (sdo_idx_r == `OBJ_ERR_REG) begin
               reply_nxt[63:32] = {24'h000000, error_register};
            end else if (sdo_idx_r == `OBJ_SYNC_WIN) begin
               reply_nxt[63:32] = {16'h0000, sync_win_ms_r};
            end else if (sdo_idx_r == `OBJ_ERR_HIST) begin
               reply_nxt[63:32] = err_hist_r[31:0];
            end else begin
               reply_nxt[63:32] = od_rd;
            end
         end
         `SDO_DL_1, `SDO_DL_2, `SDO_DL_3, `SDO_DL_4: begin
            if (sdo_idx_r == `OBJ_ERR_REG || sdo_idx_r == `OBJ_ERR_HIST) begin
               reply_nxt[7:0] = `SDO_ABORT;
               reply_nxt[63:32] = `SDO_ERR_NOOBJ;
            end else begin
               reply_nxt[7:0] = `SDO_DL_OK;
            end
         end
         default: begin
            reply_nxt[7:0] = `SDO_ABORT;
            reply_nxt[63:32] = `SDO_ERR_CMD;
         end
      endcase
   end

   always @(posedge clk) begin
      if (comm_rst_now) begin
         sdo_st_r <= S_IDLE;
         sdo_pend_r <= 1'b0;
         sdo_cmd_r <= 8'h00;
         sdo_idx_r <= 16'h0000;
         sdo_sub_r <= 8'h00;
         sdo_reply_r <= 64'h0;
         sync_win_ms_r <= 16'h0000;
         sdo_wdat_r <= 32'h00000000;
         od_we <= 1'b0;
      end else begin
         od_we <= 1'b0;
         case (sdo_st_r)
            S_IDLE: begin
               if (is_sdo && svc_on && !sdo_pend_r) begin
                  sdo_cmd_r <= rx_data[7:0];
                  sdo_idx_r <= rx_data[23:8];
                  sdo_sub_r <= rx_data[31:24];
                  if (dl_len(rx_data[7:0]) != 3'd0) begin
                     sdo_wdat_r <= rx_data[63:32] &
                        len_mask(dl_len(rx_data[7:0]));
                     od_we <= rx_data[23:8] != `OBJ_ERR_REG &&
                        rx_data[23:8] != `OBJ_ERR_HIST;
                     if (rx_data[23:8] == `OBJ_SYNC_WIN) begin
                        sync_win_ms_r <= rx_data[47:32];
                     end
                  end
                  sdo_st_r <= S_READ;
               end
            end
            S_READ: begin
               sdo_st_r <= S_SEND;
            end
            S_SEND: begin
               sdo_reply_r <= reply_nxt;
               sdo_pend_r <= 1'b1;
               sdo_st_r <= S_IDLE;
            end
            default: sdo_st_r <= S_IDLE;
         endcase
         if (sdo_take) begin
            sdo_pend_r <= 1'b0;
         end
      end
   end

   // ----------------------------------------------------------------
   // Transmit arbitration: boot-up, emergency, then SDO reply
   // ----------------------------------------------------------------
   always @(posedge clk) begin
      if (!nrst) begin
         tx_valid <= 1'b0;
         tx_id <= 11'h000;
         tx_dlc <= 4'h0;
         tx_data <= 64'h0;
      end else if (tx_valid) begin
         tx_valid <= 1'b0;
      end else if (tx_ready && node_ok) begin
         if (boot_pend_r && nmt_state == `ST_PREOP) begin
            tx_valid <= 1'b1;
            tx_id <= 11'h700 + {4'h0, node_id};
            tx_dlc <= 4'h1;
            tx_data <= 64'h0;
         end else if (emcy_take) begin
            tx_valid <= 1'b1;
            tx_id <= `ID_EMCY_BASE + {4'h0, node_id};
            tx_dlc <= 4'h8;
            tx_data <= emcy_zero_r ? 64'h0 :
               {emcy_mfr_r, error_register, emcy_code_r};
         end else if (sdo_take) begin
            tx_valid <= 1'b1;
            tx_id <= `ID_SDO_TX_BASE + {4'h0, node_id};
            tx_dlc <= 4'h8;
            tx_data <= sdo_reply_r;
         end
      end
   end
endmodule // canopen_nmt_sdo_slave
`default_nettype wire

// ---- rtl/canopen_nmt_sdo_slave_defines.vh ----
// Constants for the CANopen slave communication handler
`ifndef CANOPEN_NMT_SDO_SLAVE_DEFINES_VH
`define CANOPEN_NMT_SDO_SLAVE_DEFINES_VH

// CAN identifier bases
`define ID_NMT 11'h000
`define ID_SYNC 11'h080
`define ID_EMCY_BASE 11'h080
`define ID_SDO_RX_BASE 11'h600
`define ID_SDO_TX_BASE 11'h580
`define NODE_ID_MAX 7'h7F

// NMT command bytes
`define NMT_START 8'h01
`define NMT_STOP 8'h02
`define NMT_PREOP 8'h80
`define NMT_RST_NODE 8'h81
`define NMT_RST_COMM 8'h82

// NMT states
`define ST_INIT 2'h0
`define ST_PREOP 2'h1
`define ST_OPER 2'h2
`define ST_STOP 2'h3

// SDO command bytes
`define SDO_DL_1 8'h2F
`define SDO_DL_2 8'h2B
`define SDO_DL_3 8'h27
`define SDO_DL_4 8'h23
`define SDO_UL_REQ 8'h40
`define SDO_UL_1 8'h4F
`define SDO_UL_2 8'h4B
`define SDO_UL_3 8'h47
`define SDO_UL_4 8'h43
`define SDO_DL_OK 8'h60
`define SDO_ABORT 8'h80
`define SDO_ERR_CMD 32'h05040001
`define SDO_ERR_NOOBJ 32'h06020000

// Object indices
`define OBJ_ERR_REG 16'h1001
`define OBJ_ERR_HIST 16'h1003
`define OBJ_SYNC_WIN 16'h1007

// Timing: one millisecond at 100 MHz
`define CLK_HZ 100000000
`define MS_NS 1000000
`define CLK_NS 10
`define MS_CYCLES (`MS_NS / `CLK_NS)

`endif

// ---- rtl/od_ram.v ----
// Small object dictionary storage with registered read data
`timescale 1ns/100ps
`default_nettype none
module od_ram #(
   parameter AW = 4,
   parameter DW = 32
) (
   // Clock
   input wire clk,
   // Write port
   input wire wr_en,
   input wire [AW-1:0] wr_addr,
   input wire [DW-1:0] wr_data,
   // Read port
   input wire [AW-1:0] rd_addr,
   output reg [DW-1:0] rd_data
);
   reg [DW-1:0] mem [0:(1<<AW)-1];

   always @(posedge clk) begin
      if (wr_en) begin
         mem[wr_addr] <= wr_data;
      end
      rd_data <= mem[rd_addr];
   end
endmodule // od_ram
`default_nettype wire

// ---- verif/can_master_model.sv ----
// Bus master model: sends frames to the node and collects its frames
`timescale 1ns/100ps
`default_nettype none
module can_master_model (
   // Clock
   input wire logic clk,
   // Frames to the node
   output logic rx_valid,
   output logic [10:0] rx_id,
   output logic [3:0] rx_dlc,
   output logic [63:0] rx_data,
   // Frames from the node
   input wire logic tx_valid,
   input wire logic [10:0] tx_id,
   input wire logic [3:0] tx_dlc,
   input wire logic [63:0] tx_data,
   output logic tx_ready,
   // Stall mode
   input wire logic slow
);
   logic [78:0] got_q[$];
   initial begin
      rx_valid = 1'b0;
      rx_id = 11'h7FF;
      rx_dlc = 4'hF;
      rx_data = 64'h0;
      tx_ready = 1'b1;
   end
   // Caller builds two-byte command frames and padded eight-byte
   // service frames; reads go out as 40, index, subindex, zeros
   task automatic send(input logic [10:0] id, input logic [3:0] dlc,
                       input logic [63:0] d);
      @(posedge clk);
      #1;
      rx_valid = 1'b1;
      rx_id = id;
      rx_dlc = dlc;
      rx_data = d;
      @(posedge clk);
      #1;
      rx_valid = 1'b0;
      // Idle bus shows garbage so stale data is never mistaken for a frame
      rx_id = ~id;
      rx_data = ~d;
   endtask
   always @(posedge clk) begin
      tx_ready <= slow ? 1'($urandom) : 1'b1;
      if (tx_valid === 1'b1)
         got_q.push_back({tx_id, tx_dlc, tx_data});
   end
endmodule // can_master_model
`default_nettype wire

// ---- verif/canopen_nmt_sdo_slave_properties.sv ----
// Port-level checker for the CANopen slave communication handler
`timescale 1ns/100ps
`default_nettype none
module canopen_slave_checker (
   // Clock and reset
   input wire logic clk,
   input wire logic nrst,
   // Configuration and inputs
   input wire logic [6:0] node_id,
   input wire logic [7:0] tx_trans_type,
   input wire logic rx_valid,
   input wire logic [10:0] rx_id,
   input wire logic [3:0] rx_dlc,
   input wire logic [63:0] rx_data,
   input wire logic err_event,
   input wire logic [2:0] err_bit,
   input wire logic [31:0] app_data,
   // Outputs
   input wire logic tx_valid,
   input wire logic [10:0] tx_id,
   input wire logic [3:0] tx_dlc,
   input wire logic [31:0] tpdo_data,
   input wire logic tpdo_start,
   input wire logic [1:0] nmt_state,
   input wire logic node_reset,
   input wire logic comm_reset,
   input wire logic [7:0] error_register
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!nrst);
   // Addressed to us or broadcast; node 0 is a disabled node
   wire logic nmt_frm = rx_valid && rx_id == 11'h000 && rx_dlc == 4'h2;
   wire logic nmt_hit = nmt_frm && node_id != 7'h00 &&
      (rx_data[15:8] == 8'h00 || rx_data[15:8] == {1'b0, node_id});
   wire logic live = nmt_state != 2'h0;
   wire logic cmd_ok = tx_trans_type >= 8'h01 && tx_trans_type <= 8'hF0;

   a_nmt_start: assert property (nmt_hit && rx_data[7:0] == 8'h01 && live |=> nmt_state == 2'h2)
      else $error("start command did not reach operational");
   a_nmt_stop: assert property (nmt_hit && rx_data[7:0] == 8'h02 && live |=> nmt_state == 2'h3)
      else $error("stop command did not reach stopped");
   a_foreign_ignored: assert property (nmt_frm && rx_data[15:8] != 8'h00 &&
      rx_data[15:8] != {1'b0, node_id} && live |=> $stable(nmt_state))
      else $error("command for another node changed state");
   a_reset_node_seq: assert property (nmt_hit && rx_data[7:0] == 8'h81 && live
      |=> nmt_state == 2'h0 ##[1:2] nmt_state == 2'h1)
      else $error("reset node did not pass through init");
   a_reset_node_pulse: assert property (nmt_hit && rx_data[7:0] == 8'h81 && live
      |-> ##[1:2] node_reset)
      else $error("reset node pulse missing");
   a_reset_comm_pulse: assert property (nmt_hit && rx_data[7:0] == 8'h82 && live
      |=> comm_reset)
      else $error("reset communication pulse missing");
   a_init_leaves: assert property (nmt_state == 2'h0 |-> ##[1:2] nmt_state == 2'h1)
      else $error("init did not move to pre-operational");
   a_sdo_reply_form: assert property (tx_valid && tx_id[10:7] == 4'hB
      |-> tx_dlc == 4'h8 && tx_id[6:0] == node_id)
      else $error("bad service reply identifier or length");
   a_emcy_form: assert property (tx_valid && tx_id[10:7] == 4'h1
      |-> tx_dlc == 4'h8 && tx_id[6:0] == node_id)
      else $error("bad emergency identifier or length");
   a_sync_sample: assert property (rx_valid && rx_id == 11'h080 &&
      nmt_state == 2'h2 && node_id != 7'h00 && cmd_ok
      |=> tpdo_start && tpdo_data == $past(app_data))
      else $error("sync did not sample transmit data");
   a_pdo_oper_only: assert property (tpdo_start |-> nmt_state == 2'h2)
      else $error("process data started outside operational");
   a_error_bit: assert property (err_event && live |=> error_register[$past(err_bit)])
      else $error("error register bit not set");
endmodule // canopen_slave_checker

bind canopen_nmt_sdo_slave canopen_slave_checker u_checker (
   .clk(clk), .nrst(nrst), .node_id(node_id), .tx_trans_type(tx_trans_type),
   .rx_valid(rx_valid), .rx_id(rx_id), .rx_dlc(rx_dlc), .rx_data(rx_data),
   .err_event(err_event), .err_bit(err_bit), .app_data(app_data),
   .tx_valid(tx_valid), .tx_id(tx_id), .tx_dlc(tx_dlc), .tpdo_data(tpdo_data),
   .tpdo_start(tpdo_start), .nmt_state(nmt_state), .node_reset(node_reset),
   .comm_reset(comm_reset), .error_register(error_register));
`default_nettype wire

// ---- verif/test_canopen_nmt_sdo_slave.sv ----
// Self-checking bench for the CANopen slave communication handler
`timescale 1ns/100ps
`default_nettype none
module test_canopen_nmt_sdo_slave;
   localparam int MSC = 10;
   logic clk, nrst, rx_valid, tx_valid, tx_ready, err_event, err_clear, slow;
   logic rpdo_valid, tpdo_start, pdo_window, node_reset, comm_reset;
   logic [6:0] node_id;
   logic [7:0] tx_trans_type, error_register, exp_reg;
   logic [10:0] rx_id, tx_id;
   logic [3:0] rx_dlc, tx_dlc;
   logic [63:0] rx_data, tx_data;
   logic [15:0] emergency_error_code;
   logic [2:0] err_bit;
   logic [39:0] err_mfr_code;
   logic [31:0] rpdo_data, app_data, rpdo_committed, tpdo_data;
   logic [1:0] nmt_state;
   int fail_count, n_compared;

   canopen_nmt_sdo_slave #(.MS_CYC(MSC), .OD_AW(4)) DUT (
      .clk(clk), .nrst(nrst), .node_id(node_id), .tx_trans_type(tx_trans_type),
      .rx_valid(rx_valid), .rx_id(rx_id), .rx_dlc(rx_dlc), .rx_data(rx_data),
      .tx_valid(tx_valid), .tx_id(tx_id), .tx_dlc(tx_dlc), .tx_data(tx_data),
      .tx_ready(tx_ready), .err_event(err_event),
      .emergency_error_code(emergency_error_code), .err_bit(err_bit),
      .err_mfr_code(err_mfr_code), .err_clear(err_clear),
      .rpdo_data(rpdo_data), .rpdo_valid(rpdo_valid), .app_data(app_data),
      .rpdo_committed(rpdo_committed), .tpdo_data(tpdo_data),
      .tpdo_start(tpdo_start), .pdo_window(pdo_window), .nmt_state(nmt_state),
      .node_reset(node_reset), .comm_reset(comm_reset),
      .error_register(error_register));
   can_master_model m (
      .clk(clk), .rx_valid(rx_valid), .rx_id(rx_id), .rx_dlc(rx_dlc),
      .rx_data(rx_data), .tx_valid(tx_valid), .tx_id(tx_id), .tx_dlc(tx_dlc),
      .tx_data(tx_data), .tx_ready(tx_ready), .slow(slow));

   // ------------------------------------------------------------
   // Shared tasks
   // ------------------------------------------------------------
   task automatic check(input logic [78:0] seen, input logic [78:0] exp);
      n_compared++;
      if (seen !== exp) begin
         fail_count++;
         $display("BAD %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic results();
      $display("compared %0d, mismatches %0d", n_compared, fail_count);
      if (fail_count == 0 && n_compared > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   // A missing frame is turned into a forced mismatch
   task automatic expect_tx(input logic [10:0] id, input logic [3:0] dlc,
                            input logic [63:0] d);
      int n;
      n = 0;
      while (m.got_q.size() == 0 && n < 400) begin
         @(posedge clk);
         n++;
      end
      check(m.got_q.size() != 0 ? m.got_q.pop_front() : ~{id, dlc, d},
            {id, dlc, d});
   endtask
   task automatic sdo(input logic [7:0] c, input logic [15:0] ix,
                      input logic [7:0] sb, input logic [31:0] v);
      m.send(11'h600 + 11'(node_id), 4'h8, {v, sb, ix, c});
   endtask
   task automatic reply(input logic [7:0] c, input logic [15:0] ix,
                        input logic [7:0] sb, input logic [31:0] v);
      expect_tx(11'h580 + 11'(node_id), 4'h8, {v, sb, ix, c});
   endtask
   task automatic nmt(input logic [7:0] c, input logic [7:0] nd);
      m.send(11'h000, 4'h2, {48'h0, nd, c});
      repeat (3) @(posedge clk);
      #1;
   endtask
   task automatic pulse_err(input logic clr);
      @(posedge clk);
      #1;
      if (clr)
         err_clear = 1'b1;
      else
         err_event = 1'b1;
      @(posedge clk);
      #1;
      err_event = 1'b0;
      err_clear = 1'b0;
   endtask

   // ------------------------------------------------------------
   // Clock, watchdog and main sequence
   // ------------------------------------------------------------
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   initial begin
      #500000;
      fail_count++;
      results();
   end
   initial begin
      logic [31:0] v;
      logic [15:0] ix;
      logic [7:0] sb;
      int cnt;
      {nrst, err_event, err_clear, slow, rpdo_valid} = 5'h00;
      {rpdo_data, app_data, err_mfr_code} = 104'h0;
      {emergency_error_code, err_bit} = 19'h0;
      tx_trans_type = 8'h01;
      node_id = 7'h01;
      v = $urandom(81);
      node_id = 7'($urandom % 127 + 1);
      repeat (20) @(posedge clk);
      check(79'(nmt_state), 79'h0);
      #1 nrst = 1'b1;
      expect_tx(11'h700 + 11'(node_id), 4'h1, 64'h0);
      check(79'(nmt_state), 79'h1);
      slow = 1'b1;
      for (int k = 0; k < 4; k++) begin
         v = $urandom & (32'hFFFFFFFF >> (8 * (3 - k)));
         ix = 16'h2000 | 16'($urandom % 4096);
         sb = 8'($urandom);
         sdo(8'h2F - 8'(4 * k), ix, sb, v);
         reply(8'h60, ix, sb, 32'h0);
         sdo(8'h40, ix, sb, 32'h0);
         reply(8'h43, ix, sb, v);
      end
      sdo(8'h2B, 16'h1007, 8'h00, 32'h2);
      reply(8'h60, 16'h1007, 8'h00, 32'h0);
      sdo(8'h40, 16'h1007, 8'h00, 32'h0);
      reply(8'h4B, 16'h1007, 8'h00, 32'h2);
      sdo(8'h40, 16'h1001, 8'h00, 32'h0);
      reply(8'h4F, 16'h1001, 8'h00, 32'h0);
      sdo(8'h23, 16'h1001, 8'h00, v);
      reply(8'h80, 16'h1001, 8'h00, 32'h06020000);
      sdo(8'hA5, ix, sb, v);
      reply(8'h80, ix, sb, 32'h05040001);
      nmt(8'h01, 8'h00);
      check(79'(nmt_state), 79'h2);
      nmt(8'h02, {1'b0, 7'(node_id % 127 + 1)});
      check(79'(nmt_state), 79'h2);
      nmt(8'h02, {1'b0, node_id});
      check(79'(nmt_state), 79'h3);
      sdo(8'h40, ix, sb, 32'h0);
      repeat (60) @(posedge clk);
      check(79'(m.got_q.size()), 79'h0);
      nmt(8'h80, {1'b0, node_id});
      check(79'(nmt_state), 79'h1);
      nmt(8'h01, {1'b0, node_id});
      check(79'(nmt_state), 79'h2);
      app_data = $urandom;
      rpdo_data = $urandom;
      rpdo_valid = 1'b1;
      tx_trans_type = 8'($urandom % 240 + 1);
      m.send(11'h080, 4'h0, 64'h0);
      @(posedge clk);
      #1;
      check(79'(tpdo_data), 79'(app_data));
      // Nothing was received before this first window opened
      check(79'(rpdo_committed), 79'h0);
      cnt = 0;
      while (pdo_window === 1'b1 && cnt < 100) begin
         @(posedge clk);
         #1;
         cnt++;
      end
      // Window opened one edge before the loop started counting
      check(79'(cnt + 1), 79'(2 * MSC));
      // Data offered after the window closed must not be committed
      v = rpdo_data;
      rpdo_data = $urandom;
      m.send(11'h080, 4'h0, 64'h0);
      @(posedge clk);
      #1;
      check(79'(rpdo_committed), 79'(v));
      emergency_error_code = 16'($urandom);
      err_bit = 3'($urandom);
      err_mfr_code = {8'($urandom), $urandom};
      exp_reg = 8'h01 << err_bit;
      pulse_err(1'b0);
      expect_tx(11'h080 + 11'(node_id), 4'h8, {err_mfr_code, exp_reg,
                emergency_error_code});
      check(79'(error_register), 79'(exp_reg));
      sdo(8'h40, 16'h1003, 8'h01, 32'h0);
      reply(8'h43, 16'h1003, 8'h01, {err_mfr_code[7:0], exp_reg,
            emergency_error_code});
      pulse_err(1'b1);
      expect_tx(11'h080 + 11'(node_id), 4'h8, 64'h0);
      pulse_err(1'b0);
      expect_tx(11'h080 + 11'(node_id), 4'h8, {err_mfr_code, exp_reg,
                emergency_error_code});
      nmt(8'h82, 8'h00);
      expect_tx(11'h700 + 11'(node_id), 4'h1, 64'h0);
      check(79'(error_register), 79'(exp_reg));
      nmt(8'h81, {1'b0, node_id});
      expect_tx(11'h700 + 11'(node_id), 4'h1, 64'h0);
      check(79'(error_register), 79'h0);
      check(79'(nmt_state), 79'h1);
      results();
   end
endmodule // test_canopen_nmt_sdo_slave
`default_nettype wire
